// ==== rtl/sfp_pkg.sv ====
package sfp_pkg;
    localparam int unsigned MCLK_PERIOD_NS = 40;
    localparam int unsigned ADDR_W = 24;

    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WAKE_AND_IDENT_CMD = 8'hab;
    localparam logic [7:0] POWER_DOWN_CMD = 8'hb9;
    localparam logic [7:0] FULL_ARRAY_CLEAR_CMD = 8'hc7;
    localparam logic [7:0] REGION_CLEAR_CMD = 8'hd8;

    // status word field positions
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_WEL_POS = 1;
    localparam int unsigned ST_BP_LO = 2;
    localparam int unsigned ST_BP_HI = 3;
    localparam int unsigned ST_LOCK = 7;

    // frame lengths in whole bytes, and BIT_LAST, the last bit index in a byte
    localparam logic [2:0] LEN_SINGLE = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_REGION = 3'h4;
    localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
    localparam logic [2:0] LEN_IDENT = 3'h4;
    localparam logic [2:0] LEN_SAT = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [23:0] ARRAY_BASE = 24'h000000;
    localparam logic [23:0] HALF_BASE = 24'h020000;
    localparam logic [23:0] QUARTER_BASE = 24'h030000;
    localparam logic [23:0] ARRAY_TOP = 24'h03ffff;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_LEAD = 4'b0010,
        H_SHIFT = 4'b0100,
        H_GAP = 4'b1000
    } sfp_hstate_t;

    // least time, rounded up, never below one cycle
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction
endpackage

// ==== rtl/sfp_link_if.sv ====
`timescale 1ns/1ps
interface sfp_link_if;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    logic wp_n;
    logic pause_n;
    logic so_line;

    // pull-up on the shared output line
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input sclk,
        input cs_n,
        input si,
        input wp_n,
        input pause_n,
        output so,
        output so_oe
    );
    modport host (
        output sclk,
        output cs_n,
        output si,
        output wp_n,
        output pause_n,
        input so_line
    );
endinterface

// ==== rtl/sfp_dev.sv ====
`timescale 1ns/1ps
// Function
// RULE_01: busy flag readable for polling completion
// RULE_02: selected means active power mode
// RULE_03: deselected: active until cycle ends, then standby
// RULE_04: power-down entered only by its command
// RULE_05: power-down left only by wake command
// RULE_06: in power-down ignore all but wake
// RULE_07: block-protect bits survive power cycles
// RULE_08: refuse program/clear in protected region
// RULE_09: lock bit plus pin freezes protect bits
// RULE_10: modifying commands need whole-byte clock count
// RULE_11: modifying commands need write-enable latch set
// RULE_12: latch cleared at power-up and completions
// RULE_13: protect code maps to fixed address ranges
// RULE_14: pause never aborts a running cycle
// RULE_15: pause starts on fall while clock low
// RULE_16: pause ends on rise while clock low
// RULE_17: edge during clock high waits for low
// RULE_18: paused: output released, clock/data ignored
// RULE_19: host keeps select low through pause
// RULE_20: deselect while paused abandons the frame
// RULE_21: host raises pause before reselecting
// RULE_22: busy reads one during a cycle
// RULE_23: opcode 06h sets write-enable latch
// RULE_24: lock bit with pin low blocks status writes
module sfp_dev #(
    parameter int unsigned T_STATUS_NS = 10000,
    parameter int unsigned T_PROG_NS = 1000000,
    parameter int unsigned T_REGION_NS = 1000000,
    parameter int unsigned T_FULL_NS = 2000000,
    parameter logic [7:0] IDENT_CODE = 8'h5a, // arbitrary value
    parameter logic [1:0] NV_BP_INIT = 2'h0,
    parameter logic NV_LOCK_INIT = 1'b0
) (
    sfp_link_if.dev link,
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic nv_rst_n,
    output logic [7:0] status_word,
    output logic active_mode,
    output logic standby_mode,
    output logic power_down,
    output logic exec_valid,
    output logic [7:0] exec_op,
    output logic [sfp_pkg::ADDR_W-1:0] exec_addr
);
    import sfp_pkg::*;

    localparam int unsigned C_STATUS = ns_to_cyc(T_STATUS_NS);
    localparam int unsigned C_PROG = ns_to_cyc(T_PROG_NS);
    localparam int unsigned C_REGION = ns_to_cyc(T_REGION_NS);
    localparam int unsigned C_FULL = ns_to_cyc(T_FULL_NS);

    // ---------------- link clock domain ----------------
    logic hold_r, hold_eff, hold_now, in_frame_r, frame_tgl_r;
    logic [2:0] bit_cnt_r, byte_cnt_r;
    logic [7:0] shift_r, opcode_r, data1_r, tx_r, rx_byte, load_val;
    logic [ADDR_W-1:0] addr_r;
    logic [8:0] st_meta_r, st_sync_r;
    logic rd_en;

    // pause level at the rise holds for the whole high phase
    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= ~link.pause_n; // RULE_17
        end
    end
    // clock low: pause edge acts at once; high: level at the rise
    assign hold_eff = ~link.cs_n
        & (link.sclk ? hold_r : ~link.pause_n); // RULE_15 RULE_16
    // edges read the pin, as hold_eff races the clock itself
    assign hold_now = ~link.cs_n & ~link.pause_n; // RULE_15 RULE_16

    always_ff @(posedge link.sclk or negedge rst_n or posedge link.cs_n)
    begin
        if (!rst_n) begin
            in_frame_r <= 1'b0;
        end else if (link.cs_n) begin
            in_frame_r <= 1'b0;
        end else if (!hold_now) begin
            in_frame_r <= 1'b1;
        end
    end

    assign rx_byte = {shift_r[6:0], link.si};

    // frame registers keep their value after deselect for mclk
    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            opcode_r <= 8'h00;
            data1_r <= 8'h00;
            addr_r <= '0;
            frame_tgl_r <= 1'b0;
        end else if (!link.cs_n && !hold_now) begin // RULE_18
            if (!in_frame_r) begin
                bit_cnt_r <= 3'h1;
                byte_cnt_r <= 3'h0;
                shift_r <= {7'h00, link.si};
                frame_tgl_r <= ~frame_tgl_r;
            end else begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                shift_r <= rx_byte;
                if (bit_cnt_r == BIT_LAST) begin
                    if (byte_cnt_r != LEN_SAT) begin
                        byte_cnt_r <= byte_cnt_r + 3'h1;
                    end
                    if (byte_cnt_r == 3'h0) begin
                        opcode_r <= rx_byte;
                    end
                    if (byte_cnt_r == 3'h1) begin
                        data1_r <= rx_byte;
                    end
                    if (byte_cnt_r != 3'h0 && byte_cnt_r < LEN_REGION) begin
                        addr_r <= {addr_r[15:0], rx_byte};
                    end
                end
            end
        end
    end

    // per-bit flags, each a slow level; stale only for first edges
    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            st_meta_r <= '0;
            st_sync_r <= '0;
        end else begin
            st_meta_r <= {power_down, status_word};
            st_sync_r <= st_meta_r;
        end
    end

    assign rd_en = in_frame_r && byte_cnt_r != 3'h0
        && ((opcode_r == STATUS_READ_CMD && !st_sync_r[8]) // RULE_06
        || (opcode_r == WAKE_AND_IDENT_CMD && byte_cnt_r >= LEN_IDENT));
    assign load_val = (opcode_r == WAKE_AND_IDENT_CMD) ? IDENT_CODE
        : st_sync_r[7:0];

    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= 8'h00;
        end else if (in_frame_r && !hold_now) begin
            tx_r <= (bit_cnt_r == 3'h0) ? load_val : {tx_r[6:0], 1'b0};
        end
    end

    assign link.so = tx_r[7];
    assign link.so_oe = rd_en & ~hold_eff; // RULE_18

    // ---------------- mclk domain ----------------
    logic [2:0] pin_meta_r, pin_sync_r;
    logic cs_last_r, seen_tgl_r, frame_end, whole;
    logic wel_r, busy_r, dpd_r, lock_r, hw_lock, prot_hit;
    logic [1:0] bp_r;
    logic [31:0] busy_cnt_r;
    logic go_wen, go_wdis, go_pd, go_wake, go_stat, go_prog, go_clr,
        go_full, busy_done;

    // {cs_n, pause_n, wp_n}
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= 3'h7;
            pin_sync_r <= 3'h7;
            cs_last_r <= 1'b1;
        end else begin
            pin_meta_r <= {link.cs_n, link.pause_n, link.wp_n};
            pin_sync_r <= pin_meta_r;
            cs_last_r <= pin_sync_r[2];
        end
    end

    // link-side frame registers are quiet once select is high
    assign frame_end = pin_sync_r[2] & ~cs_last_r
        & (frame_tgl_r != seen_tgl_r);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seen_tgl_r <= 1'b0;
        end else if (pin_sync_r[2] & ~cs_last_r) begin
            seen_tgl_r <= frame_tgl_r;
        end
    end

    assign whole = bit_cnt_r == 3'h0 && byte_cnt_r != 3'h0; // RULE_10
    assign hw_lock = lock_r & ~pin_sync_r[0]; // RULE_09 RULE_24

    always_comb begin
        unique case (bp_r) // RULE_13
            BP_ALL: prot_hit = addr_r >= ARRAY_BASE && addr_r <= ARRAY_TOP;
            BP_HALF: prot_hit = addr_r >= HALF_BASE && addr_r <= ARRAY_TOP;
            BP_QUARTER:
                prot_hit = addr_r >= QUARTER_BASE && addr_r <= ARRAY_TOP;
            BP_NONE: prot_hit = 1'b0;
        endcase
    end

    always_comb begin
        go_wen = 1'b0;
        go_wdis = 1'b0;
        go_pd = 1'b0;
        go_wake = 1'b0;
        go_stat = 1'b0;
        go_prog = 1'b0;
        go_clr = 1'b0;
        go_full = 1'b0;
        // deselect while paused drops the frame
        if (frame_end && pin_sync_r[1]) begin // RULE_20
            if (dpd_r) begin
                go_wake = opcode_r == WAKE_AND_IDENT_CMD
                    && byte_cnt_r != 3'h0; // RULE_05 RULE_06
            end else if (whole && !busy_r) begin
                unique case (opcode_r)
                    WRITE_ENABLE_CMD: go_wen = byte_cnt_r == LEN_SINGLE;
                    WRITE_DISABLE_CMD: go_wdis = byte_cnt_r == LEN_SINGLE;
                    POWER_DOWN_CMD: go_pd = byte_cnt_r == LEN_SINGLE;
                    STATUS_WRITE_CMD: go_stat = wel_r && !hw_lock
                        && byte_cnt_r == LEN_STATUS_WRITE; // RULE_11
                    PAGE_PROGRAM_CMD: go_prog = wel_r && !prot_hit
                        && byte_cnt_r >= LEN_PROGRAM_MIN; // RULE_08
                    REGION_CLEAR_CMD: go_clr = wel_r && !prot_hit
                        && byte_cnt_r == LEN_REGION; // RULE_08
                    FULL_ARRAY_CLEAR_CMD: go_full = wel_r
                        && bp_r == BP_NONE && byte_cnt_r == LEN_SINGLE;
                    default: ;
                endcase
            end
        end
    end

    assign busy_done = busy_r && busy_cnt_r == 32'h1;

    // the pause pin has no path here, so cycles run to the end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            busy_cnt_r <= 32'h0;
        end else if (go_stat | go_prog | go_clr | go_full) begin
            busy_r <= 1'b1; // RULE_22 RULE_01
            busy_cnt_r <= go_stat ? C_STATUS : go_prog ? C_PROG
                : go_clr ? C_REGION : C_FULL;
        end else if (busy_done) begin
            busy_r <= 1'b0; // RULE_14
            busy_cnt_r <= 32'h0;
        end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r - 32'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wel_r <= 1'b0; // RULE_12
        end else if (go_wen) begin
            wel_r <= 1'b1; // RULE_23
        end else if (go_wdis || busy_done) begin
            wel_r <= 1'b0; // RULE_12
        end
    end

    // separate reset: not disturbed by rst_n power cycles
    always_ff @(posedge mclk or negedge nv_rst_n) begin
        if (!nv_rst_n) begin
            bp_r <= NV_BP_INIT;
            lock_r <= NV_LOCK_INIT;
        end else if (go_stat) begin
            bp_r <= {data1_r[ST_BP_HI], data1_r[ST_BP_LO]}; // RULE_07
            lock_r <= data1_r[ST_LOCK];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dpd_r <= 1'b0;
        end else if (go_pd) begin
            dpd_r <= 1'b1; // RULE_04
        end else if (go_wake) begin
            dpd_r <= 1'b0; // RULE_05
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            exec_valid <= 1'b0;
            exec_op <= 8'h00;
            exec_addr <= '0;
        end else begin
            exec_valid <= go_stat | go_prog | go_clr | go_full;
            if (go_stat | go_prog | go_clr | go_full) begin
                exec_op <= opcode_r;
                exec_addr <= addr_r;
            end
        end
    end

    assign status_word = {lock_r, 3'h0, bp_r, wel_r, busy_r};
    assign active_mode = ~pin_sync_r[2] | busy_r; // RULE_02 RULE_03
    assign standby_mode = ~active_mode & ~dpd_r; // RULE_03
    assign power_down = dpd_r;
endmodule

// ==== rtl/sfp_host.sv ====
`timescale 1ns/1ps
module sfp_host #(
    parameter int unsigned HALF_CYC = 3,
    parameter int unsigned GAP_CYC = 8
) (
    sfp_link_if.host link,
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [6:0] cmd_bits,
    input wire logic [63:0] cmd_tx,
    input wire logic pause_req,
    input wire logic wp_level,
    output logic rsp_valid,
    output logic [63:0] rsp_data
);
    import sfp_pkg::*;

    sfp_hstate_t state_r;
    logic sclk_r, cs_n_r, pause_n_r, wp_r, so_meta_r, so_sync_r;
    logic [63:0] tx_r;
    logic [6:0] bits_r;
    logic [7:0] div_r;
    logic half_end;

    assign half_end = div_r == 8'(HALF_CYC - 1);
    // a new frame waits until pause is released
    assign cmd_ready = state_r == H_IDLE && pause_n_r && !pause_req;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            so_meta_r <= 1'b1;
            so_sync_r <= 1'b1;
            wp_r <= 1'b1;
        end else begin
            so_meta_r <= link.so_line;
            so_sync_r <= so_meta_r;
            wp_r <= wp_level;
        end
    end

    // pause pin changes only while the clock sits low; entry only
    // mid-frame and never on the edge that raises the clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pause_n_r <= 1'b1;
        end else if (!sclk_r && (!pause_n_r
            || (state_r == H_SHIFT && !half_end))) begin
            pause_n_r <= ~pause_req;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= H_IDLE;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            tx_r <= 64'h0;
            bits_r <= 7'h0;
            div_r <= 8'h0;
            rsp_valid <= 1'b0;
            rsp_data <= 64'h0;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state_r)
                H_IDLE: begin
                    if (cmd_valid && cmd_ready) begin // RULE_21
                        cs_n_r <= 1'b0;
                        tx_r <= cmd_tx;
                        bits_r <= cmd_bits;
                        div_r <= 8'h0;
                        state_r <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    div_r <= div_r + 8'h1;
                    if (half_end) begin
                        div_r <= 8'h0;
                        state_r <= (bits_r == 7'h0) ? H_GAP : H_SHIFT;
                        cs_n_r <= (bits_r == 7'h0);
                    end
                end
                H_SHIFT: begin
                    // select stays low through a pause
                    if (pause_n_r) begin // RULE_19
                        div_r <= div_r + 8'h1;
                        if (half_end) begin
                            div_r <= 8'h0;
                            sclk_r <= ~sclk_r;
                            if (!sclk_r) begin
                                rsp_data <= {rsp_data[62:0], so_sync_r};
                            end else begin
                                tx_r <= {tx_r[62:0], 1'b0};
                                bits_r <= bits_r - 7'h1;
                                if (bits_r == 7'h1) begin
                                    state_r <= H_GAP;
                                end
                            end
                        end
                    end else begin
                        // full low phase after release lets so settle
                        div_r <= 8'h0;
                    end
                end
                H_GAP: begin
                    // select rises a cycle after the last clock fall
                    cs_n_r <= 1'b1;
                    div_r <= div_r + 8'h1;
                    if (div_r == 8'(GAP_CYC - 1)) begin
                        div_r <= 8'h0;
                        rsp_valid <= 1'b1;
                        state_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign link.si = tx_r[63];
    assign link.pause_n = pause_n_r;
    assign link.wp_n = wp_r;
endmodule

// ==== verif/sfp_assertions.sv ====
`timescale 1ns/1ps
module sfp_assertions (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic wp_n,
    input wire logic pause_n,
    input wire logic so_line
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // mode 0: the link clock rests low between frames
    property p_idle_clk;
        cs_n |-> !sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("link clock high while deselected");

    property p_pause_edge;
        $changed(pause_n) |-> !sclk;
    endproperty
    a_pause_edge: assert property (p_pause_edge)
        else $error("pause pin moved while link clock high");

    property p_clk_frozen;
        !pause_n && $past(!pause_n) |-> $stable(sclk);
    endproperty
    a_clk_frozen: assert property (p_clk_frozen)
        else $error("link clock moved during pause");

    property p_cs_kept;
        $rose(cs_n) |-> pause_n && $past(pause_n);
    endproperty
    a_cs_kept: assert property (p_cs_kept)
        else $error("deselect while paused");

    property p_reselect;
        $fell(cs_n) |-> pause_n;
    endproperty
    a_reselect: assert property (p_reselect)
        else $error("select with pause pin low");

    // a short deselect could be missed by the synchronisers
    property p_gap;
        $rose(cs_n) |=> cs_n [*6];
    endproperty
    a_gap: assert property (p_gap)
        else $error("deselect gap too short");

    // sclk high for exactly three mclk cycles at the bench's divider
    property p_half;
        $rose(sclk) |-> sclk [*3] ##1 !sclk;
    endproperty
    a_half: assert property (p_half)
        else $error("link clock high phase wrong");

    property p_byte_end;
        $rose(cs_n) |-> !sclk && $past(!sclk);
    endproperty
    a_byte_end: assert property (p_byte_end)
        else $error("deselect with link clock high");

    property p_paused_off;
        !pause_n [*3] |-> !so_oe;
    endproperty
    a_paused_off: assert property (p_paused_off)
        else $error("output driven during pause");

    property p_so_fall;
        so_oe && $past(so_oe) && $changed(so) |-> !sclk;
    endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("output changed off the falling edge");

    c_frame: cover property ($fell(cs_n));
    c_pause: cover property (!pause_n && !cs_n);
    c_read: cover property (so_oe [*8]);
    c_lock: cover property (!wp_n && $fell(cs_n));
endmodule

// ==== verif/sfp_tb.sv ====
`timescale 1ns/1ps
module sfp_tb;
    import sfp_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
    logic mclk = 0, rst_n = 0, nv_rst_n = 0;
    logic cmd_valid = 0, pause_req = 0, wp_level = 1;
    logic [6:0] cmd_bits = 0;
    logic [63:0] cmd_tx = 0;
    logic cmd_ready, rsp_valid, active_mode, standby_mode, power_down;
    logic exec_valid;
    logic [63:0] rsp_data;
    logic [7:0] status_word, exec_op, st2;
    logic [23:0] exec_addr;
    logic [1:0] e_bp = 0;
    logic e_lock = 0;
    logic [31:0] seed = 32'h00012788;
    int fail_count = 0, samples_checked = 0, exec_cnt = 0;

    sfp_link_if link();
    sfp_link_if link2();
    always #20 mclk = ~mclk;
    always @(posedge mclk) if (exec_valid === 1'b1) exec_cnt <= exec_cnt + 1;

    sfp_dev #(.T_STATUS_NS(400), .T_PROG_NS(8000), .T_REGION_NS(400),
        .T_FULL_NS(400), .IDENT_CODE(ID_VAL)) sfp_dev_i (.link(link),
        .mclk(mclk), .rst_n(rst_n), .nv_rst_n(nv_rst_n),
        .status_word(status_word), .active_mode(active_mode),
        .standby_mode(standby_mode), .power_down(power_down),
        .exec_valid(exec_valid), .exec_op(exec_op), .exec_addr(exec_addr));
    // second device faces the bench, which breaks the host's habits
    sfp_dev sfp_dev_i2 (.link(link2), .mclk(mclk), .rst_n(rst_n),
        .nv_rst_n(nv_rst_n), .status_word(st2), .active_mode(),
        .standby_mode(), .power_down(), .exec_valid(), .exec_op(),
        .exec_addr());
    sfp_host sfp_host_i (.link(link), .mclk(mclk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_bits(cmd_bits),
        .cmd_tx(cmd_tx), .pause_req(pause_req), .wp_level(wp_level),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    sfp_assertions sfp_assertions_i (.mclk(mclk), .rst_n(rst_n),
        .sclk(link.sclk), .cs_n(link.cs_n), .si(link.si), .so(link.so),
        .so_oe(link.so_oe), .wp_n(link.wp_n), .pause_n(link.pause_n),
        .so_line(link.so_line));

    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic prot(input logic [1:0] bp, input logic [23:0] a);
        case (bp)
            BP_ALL: return 1'b1;
            BP_HALF: return a >= HALF_BASE;
            BP_QUARTER: return a >= QUARTER_BASE;
            default: return 1'b0;
        endcase
    endfunction

    task frame(input logic [6:0] nb, input logic [63:0] tx);
        int n;
        @(negedge mclk);
        cmd_bits = nb;
        cmd_tx = tx;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk(n < 3000, 1'b1);
        repeat (4) @(negedge mclk);
    endtask

    task op1(input logic [7:0] op);
        frame(7'd8, {op, 56'h0});
    endtask

    task poll();
        for (int n = 0; n < 40; n++) begin
            frame(7'd16, {STATUS_READ_CMD, 56'h0});
            chk(rsp_data[7:2], {e_lock, 3'h0, e_bp});
            if (rsp_data[ST_BUSY] === 1'b0) break;
            // busy may end after the read sampled it
            chk(active_mode, status_word[ST_BUSY]);
        end
        chk(standby_mode, 1'b1);
    endtask

    task wsr(input logic [7:0] v);
        logic ok;
        ok = !(e_lock && !wp_level);
        op1(WRITE_ENABLE_CMD);
        frame(7'd16, {STATUS_WRITE_CMD, v, 48'h0});
        if (ok) begin
            e_bp = v[3:2];
            e_lock = v[7];
        end
        poll();
        chk(status_word[ST_WEL_POS], !ok);
    endtask

    task bits2(input logic [7:0] v, input int n);
        for (int k = 7; k > 7 - n; k--) begin
            link2.si = v[k];
            #62.5 link2.sclk = 1'b1;
            #62.5 link2.sclk = 1'b0;
        end
    endtask

    initial begin
        #3200000;
        fail_count++;
        stop_test();
    end

    initial begin
        int n;
        logic [31:0] r;
        logic [23:0] a;
        logic [1:0] bp;
        logic ok;
        logic [23:0] corner [4];
        corner = '{24'h01ffff, 24'h020000, 24'h02ffff, 24'h030000};
        link2.sclk = 0;
        link2.cs_n = 1;
        link2.si = 0;
        link2.wp_n = 1;
        link2.pause_n = 1;
        repeat (12) @(negedge mclk);
        rst_n = 1;
        nv_rst_n = 1;
        @(negedge mclk);
        chk(status_word, 8'h00);
        chk({active_mode, standby_mode, power_down}, 3'b010);
        op1(WRITE_ENABLE_CMD);
        chk(status_word[ST_WEL_POS], 1'b1);
        op1(WRITE_DISABLE_CMD);
        chk(status_word[ST_WEL_POS], 1'b0);
        frame(7'd40, {PAGE_PROGRAM_CMD, 24'h0, 8'h55, 24'h0});
        chk(exec_cnt, 0);
        op1(WRITE_ENABLE_CMD);
        frame(7'd17, {STATUS_WRITE_CMD, 8'h0c, 48'h0});
        chk(exec_cnt, 0);
        // every protect code against each region boundary, then random
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            bp = (i < 16) ? i[1:0] : r[1:0];
            a = (i < 16) ? corner[i / 4] : {6'h0, r[25:8]};
            wsr({4'h0, bp, 2'h0});
            op1(WRITE_ENABLE_CMD);
            n = exec_cnt;
            ok = !prot(bp, a);
            if (r[31]) frame(7'd40, {PAGE_PROGRAM_CMD, a, r[15:8], 24'h0});
            else frame(7'd32, {REGION_CLEAR_CMD, a, 32'h0});
            chk(exec_cnt - n, ok);
            if (ok) chk({exec_op, exec_addr},
                {r[31] ? PAGE_PROGRAM_CMD : REGION_CLEAR_CMD, a});
            poll();
            chk(status_word[ST_WEL_POS], !ok);
        end
        wsr(8'h04);
        op1(WRITE_ENABLE_CMD);
        n = exec_cnt;
        op1(FULL_ARRAY_CLEAR_CMD);
        chk(exec_cnt - n, 0);
        wsr(8'h84);
        wp_level = 1'b0;
        wsr(8'h00);
        chk(status_word[7:2], 6'h21);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        chk(status_word, 8'h84);
        wp_level = 1'b1;
        wsr(8'h00);
        op1(WRITE_ENABLE_CMD);
        frame(7'd40, {PAGE_PROGRAM_CMD, 24'h0, 8'ha5, 24'h0});
        fork
            frame(7'd16, {STATUS_READ_CMD, 56'h0});
            begin
                repeat (70) @(negedge mclk);
                pause_req = 1'b1;
                repeat (20) @(negedge mclk);
                chk(link.so_oe, 1'b0);
                chk(status_word[ST_BUSY], 1'b1);
                pause_req = 1'b0;
            end
        join
        chk(rsp_data[7:2], 6'h00);
        poll();
        chk(status_word[ST_WEL_POS], 1'b0);
        op1(POWER_DOWN_CMD);
        chk(power_down, 1'b1);
        op1(WRITE_ENABLE_CMD);
        chk(status_word[ST_WEL_POS], 1'b0);
        frame(7'd40, {WAKE_AND_IDENT_CMD, 56'h0});
        chk(rsp_data[7:0], ID_VAL);
        chk(power_down, 1'b0);
        link2.cs_n = 1'b0;
        bits2(WRITE_ENABLE_CMD, 8);
        link2.pause_n = 1'b0;
        #200 link2.cs_n = 1'b1;
        #1000 chk(st2[ST_WEL_POS], 1'b0);
        link2.pause_n = 1'b1;
        #200 link2.cs_n = 1'b0;
        bits2(WRITE_ENABLE_CMD, 4);
        link2.pause_n = 1'b0;
        #200 bits2(8'hff, 3);
        link2.pause_n = 1'b1;
        #200 bits2({WRITE_ENABLE_CMD[3:0], 4'h0}, 4);
        link2.cs_n = 1'b1;
        #1000 chk(st2[ST_WEL_POS], 1'b1);
        stop_test();
    end
endmodule
